// *** rtl/cpm_cfg.svh ***
// constants for the current and power factor monitor: counts, thresholds, reset values
// assumes a 125 MHz mclk and settings already scaled to hundredths by the settings path
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

`define CPM_CLK_PERIOD_NS 8
`define CPM_TICK_S 1
`define CPM_NS_PER_S 1000000000
`define CPM_TICK_CYCLES ((`CPM_TICK_S * `CPM_NS_PER_S) / `CPM_CLK_PERIOD_NS)

`define CPM_VOLT_MIN 16'h001e
`define CPM_PF_SCALE 48'sh000000000064

`define CPM_EL_PHASE 0
`define CPM_EL_NEUTRAL 1
`define CPM_EL_PF1 2
`define CPM_EL_PF2 3
`define CPM_NUM_EL 4

`define CPM_RELAY_RST 5'h00
`define CPM_FLAGS_RST 4'h0

`endif

// *** rtl/cpm_pkg.sv ***
// types for the current and power factor monitor
// assumes measurement and setting words are in hundredths (x CT, x nominal, pf)
package cpm_pkg;

	typedef enum logic [1:0] {
		CPM_DISABLED,
		CPM_ALARM,
		CPM_LATCHED,
		CPM_CONTROL
	} cpm_mode_t;

	// current level element settings; pickup 5..2000 means 0.05..20.00 x CT
	typedef struct packed {
		cpm_mode_t mode;
		logic [4:0] relays;
		logic [15:0] pickup;
		logic [15:0] delay_s;
	} cpm_cur_set_t;

	// power factor element settings; levels -99..100 in hundredths, positive is lagging
	typedef struct packed {
		cpm_mode_t mode;
		logic [4:0] relays;
		logic signed [7:0] pickup;
		logic signed [7:0] dropout;
		logic [15:0] delay_s;
	} cpm_pf_set_t;

	// per phase currents and voltages, per phase real and apparent power
	typedef struct packed {
		logic [15:0] i_a;
		logic [15:0] i_b;
		logic [15:0] i_c;
		logic [15:0] i_n;
		logic [15:0] v_a;
		logic [15:0] v_b;
		logic [15:0] v_c;
		logic signed [31:0] p_a;
		logic signed [31:0] p_b;
		logic signed [31:0] p_c;
		logic [31:0] s_a;
		logic [31:0] s_b;
		logic [31:0] s_c;
	} cpm_meas_t;

endpackage

// *** rtl/cpm_timer.sv ***
// seconds delay timer for one monitoring element
// assumes tick is a one-cycle pulse once per second from the parent
`timescale 1ns/10ps

module cpm_timer import cpm_pkg::*; #(
	parameter int DLY_W = 16
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic run,
	input wire logic [DLY_W-1:0] delay_s,
	output logic done
);

	typedef struct packed {
		logic [DLY_W-1:0] cnt;
	} cpm_tmr_t;

	cpm_tmr_t st;
	cpm_tmr_t next_st;

	// the count restarts whenever the condition breaks and after each expiry,
	// so a new phase of the element never inherits elapsed time
	// the shared tick is not aligned to the condition, so a nonzero delay waits one tick past
	// the setting: never short, at most one second long
	assign done = run && ((delay_s == '0) || (st.cnt > delay_s));

	always_comb begin
		next_st = st;
		if (!run || done) begin
			next_st.cnt = '0;
		end else if (tick && (st.cnt != {DLY_W{1'b1}})) begin
			next_st.cnt = st.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // cpm_timer

// *** rtl/cpm_monitor.sv ***
// phase current, neutral current and two power factor monitoring elements
// assumes measurements are synchronous to mclk and settings are held steady by software
//
// Summary of operation
// (RULE_01) Phase current element takes disabled, alarm, latched alarm or control, and does nothing when disabled.
// (RULE_02) Neutral current element takes only disabled, alarm or control; a latched code acts as disabled.
// (RULE_03) Every element carries a mask of aux relays 3 to 7 and drives exactly those while it operates.
// (RULE_04) Current pickups run 0.05 to 20.00 x CT in 0.01 steps and the measured current is compared to them.
// (RULE_05) Every element has a 0 to 60000 s delay in 1 s steps that must run out before its output changes; current elements here drop at once below pickup.
// (RULE_06) Power factor is total three phase real power over total three phase apparent power.
// (RULE_07) There are two independent power factor elements, each with its own full set of settings.
// (RULE_08) Power factor pickup and dropout run -0.99 to 1.00 in 0.01 steps, positive meaning lagging.
// (RULE_09) A power factor element operates once the factor stays below pickup for longer than its delay.
// (RULE_10) An operated power factor element resets once the factor stays above dropout for longer than its delay.
// (RULE_11) Power factor elements are inhibited unless all three voltages exceed 30% and some phase current is nonzero.
// (RULE_12) A power factor timer advances only with all voltages above 30% and the factor beyond the relevant level.
// (RULE_13) Voltage falling below 30% while a power factor timer runs resets the element without operating.
// (RULE_14) Loss of voltage in any state, operated included, returns both power factor elements to reset at once.
// (RULE_15) Latched alarm holds until an explicit reset command, and control mode raises no alarm.
// (RULE_16) A current element operates after its current stays at or above pickup for the delay and drops when below.
`timescale 1ns/10ps

`include "cpm_cfg.svh"

module cpm_monitor import cpm_pkg::*; #(
	parameter int TICK_CYCLES = `CPM_TICK_CYCLES,
	parameter int DLY_W = 16
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire cpm_meas_t meas,
	input wire cpm_cur_set_t phase_set,
	input wire cpm_cur_set_t neutral_set,
	input wire cpm_pf_set_t pf1_set,
	input wire cpm_pf_set_t pf2_set,
	input wire logic alarm_reset,
	output logic [4:0] relay_out,
	output logic [3:0] alarm,
	output logic [3:0] operated,
	output logic pf_inhibit
);

	typedef struct packed {
		logic [31:0] presc;
		logic tick;
		logic [3:0] op;
		logic [3:0] latch;
		logic [4:0] relay;
		logic [3:0] alarm;
		logic inhibit;
	} cpm_state_t;

	cpm_state_t st;
	cpm_state_t next_st;

	cpm_mode_t mode_a [`CPM_NUM_EL];
	logic [4:0] mask_a [`CPM_NUM_EL];
	logic [DLY_W-1:0] delay_a [`CPM_NUM_EL];
	logic [3:0] run;
	logic [3:0] done;
	logic [3:0] en;
	logic [15:0] i_max;
	logic signed [33:0] p_sum;
	logic [33:0] s_sum;
	logic volt_ok;
	logic cur_ok;
	logic pf_ok;
	logic [1:0] pf_below;
	logic [1:0] pf_above;

	// sign of (pf - level) without a divider: P*100 - level*S, valid since S is never negative
	function automatic logic signed [47:0] pf_diff(
		input logic signed [33:0] p,
		input logic [33:0] s,
		input logic signed [7:0] lvl
	);
		logic signed [47:0] lhs;
		logic signed [47:0] rhs;
		lhs = 48'(p) * `CPM_PF_SCALE;
		rhs = 48'(lvl) * $signed({14'h0000, s});
		return lhs - rhs;
	endfunction

	function automatic logic [15:0] max3(
		input logic [15:0] a,
		input logic [15:0] b,
		input logic [15:0] c
	);
		logic [15:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction

	// settings gathered per element so the common logic can loop over them
	always_comb begin
		mode_a[`CPM_EL_PHASE] = phase_set.mode; // see RULE_01
		mode_a[`CPM_EL_NEUTRAL] = (neutral_set.mode == CPM_LATCHED) ? CPM_DISABLED : neutral_set.mode; // see RULE_02
		mode_a[`CPM_EL_PF1] = pf1_set.mode; // see RULE_07
		mode_a[`CPM_EL_PF2] = pf2_set.mode;
		mask_a[`CPM_EL_PHASE] = phase_set.relays;
		mask_a[`CPM_EL_NEUTRAL] = neutral_set.relays;
		mask_a[`CPM_EL_PF1] = pf1_set.relays;
		mask_a[`CPM_EL_PF2] = pf2_set.relays;
		delay_a[`CPM_EL_PHASE] = DLY_W'(phase_set.delay_s);
		delay_a[`CPM_EL_NEUTRAL] = DLY_W'(neutral_set.delay_s);
		delay_a[`CPM_EL_PF1] = DLY_W'(pf1_set.delay_s);
		delay_a[`CPM_EL_PF2] = DLY_W'(pf2_set.delay_s);
	end

	always_comb begin
		for (int k = 0; k < `CPM_NUM_EL; k++) begin
			en[k] = (mode_a[k] != CPM_DISABLED);
		end
	end

	// measured quantities and the gates on the power factor elements
	always_comb begin
		i_max = max3(meas.i_a, meas.i_b, meas.i_c);
		p_sum = 34'(meas.p_a) + 34'(meas.p_b) + 34'(meas.p_c); // see RULE_06
		s_sum = 34'(meas.s_a) + 34'(meas.s_b) + 34'(meas.s_c);
		volt_ok = (meas.v_a > `CPM_VOLT_MIN) && (meas.v_b > `CPM_VOLT_MIN) && (meas.v_c > `CPM_VOLT_MIN);
		cur_ok = (meas.i_a != 16'h0000) || (meas.i_b != 16'h0000) || (meas.i_c != 16'h0000);
		pf_ok = volt_ok && cur_ok; // see RULE_11
		// levels are signed hundredths, so numerically lower means more lagging
		pf_below[0] = pf_diff(p_sum, s_sum, pf1_set.pickup) < 48'sh0; // see RULE_08
		pf_below[1] = pf_diff(p_sum, s_sum, pf2_set.pickup) < 48'sh0;
		pf_above[0] = pf_diff(p_sum, s_sum, pf1_set.dropout) > 48'sh0;
		pf_above[1] = pf_diff(p_sum, s_sum, pf2_set.dropout) > 48'sh0;
	end

	// conditions that let each delay timer advance
	always_comb begin
		run[`CPM_EL_PHASE] = en[`CPM_EL_PHASE] && (i_max >= phase_set.pickup); // see RULE_04
		run[`CPM_EL_NEUTRAL] = en[`CPM_EL_NEUTRAL] && (meas.i_n >= neutral_set.pickup); // see RULE_16
		for (int j = 0; j < 2; j++) begin
			// pickup side while reset, dropout side while operated
			run[`CPM_EL_PF1 + j] = en[`CPM_EL_PF1 + j] && pf_ok &&
				(st.op[`CPM_EL_PF1 + j] ? pf_above[j] : pf_below[j]); // see RULE_12
		end
	end

	for (genvar g = 0; g < `CPM_NUM_EL; g++) begin : g_tmr
		cpm_timer #(
			.DLY_W(DLY_W)
		) u_tmr (
			.mclk(mclk),
			.rst_b(rst_b),
			.tick(st.tick),
			.run(run[g]),
			.delay_s(delay_a[g]),
			.done(done[g]) // see RULE_05
		);
	end

	always_comb begin
		next_st = st;
		// shared one second tick; timers with a nonzero delay wait one tick past their setting so no delay is cut short
		if (st.presc >= 32'(TICK_CYCLES - 1)) begin
			next_st.presc = 32'h00000000;
			next_st.tick = 1'b1;
		end else begin
			next_st.presc = st.presc + 32'h00000001;
			next_st.tick = 1'b0;
		end
		// current elements: operate after the full delay, drop as soon as current is below pickup
		for (int k = `CPM_EL_PHASE; k <= `CPM_EL_NEUTRAL; k++) begin
			next_st.op[k] = run[k] && (st.op[k] || done[k]); // see RULE_16
		end
		for (int k = `CPM_EL_PF1; k <= `CPM_EL_PF2; k++) begin
			if (!en[k] || !volt_ok) begin
				next_st.op[k] = 1'b0; // see RULE_13 // see RULE_14
			end else if (done[k]) begin
				// reaching the delay on the pickup side operates, on the dropout side resets
				next_st.op[k] = !st.op[k]; // see RULE_09 // see RULE_10
			end else begin
				next_st.op[k] = st.op[k];
			end
		end
		next_st.relay = `CPM_RELAY_RST;
		for (int k = 0; k < `CPM_NUM_EL; k++) begin
			if (next_st.op[k]) begin
				next_st.relay = next_st.relay | mask_a[k]; // see RULE_03
			end
			// the set wins over a reset command arriving in the same cycle
			next_st.latch[k] = (mode_a[k] == CPM_LATCHED) &&
				(next_st.op[k] || (st.latch[k] && !alarm_reset)); // see RULE_15
			unique case (mode_a[k])
				CPM_ALARM: begin
					next_st.alarm[k] = next_st.op[k];
				end
				CPM_LATCHED: begin
					next_st.alarm[k] = next_st.latch[k];
				end
				CPM_CONTROL, CPM_DISABLED: begin
					next_st.alarm[k] = 1'b0; // see RULE_01
				end
			endcase
		end
		next_st.inhibit = !pf_ok;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st.presc <= 32'h00000000;
			st.tick <= 1'b0;
			st.op <= `CPM_FLAGS_RST;
			st.latch <= `CPM_FLAGS_RST;
			st.relay <= `CPM_RELAY_RST;
			st.alarm <= `CPM_FLAGS_RST;
			st.inhibit <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign relay_out = st.relay;
	assign alarm = st.alarm;
	assign operated = st.op;
	assign pf_inhibit = st.inhibit;

endmodule // cpm_monitor

// *** test/cpm_props.sv ***
// assertions on the ports of cpm_monitor
// assumes one mclk domain and rst_b low for reset
`timescale 1ns/10ps
module cpm_props import cpm_pkg::*; (
	input wire logic mclk,
	input wire logic rst_b,
	input wire cpm_meas_t meas,
	input wire cpm_cur_set_t phase_set,
	input wire cpm_cur_set_t neutral_set,
	input wire cpm_pf_set_t pf1_set,
	input wire cpm_pf_set_t pf2_set,
	input wire logic alarm_reset,
	input wire logic [4:0] relay_out,
	input wire logic [3:0] alarm,
	input wire logic [3:0] operated,
	input wire logic pf_inhibit
);
	logic [15:0] imax;
	logic vlow;
	logic cur_hi;
	always_comb begin
		imax = (meas.i_a > meas.i_b) ? meas.i_a : meas.i_b;
		if (meas.i_c > imax) begin
			imax = meas.i_c;
		end
		vlow = (meas.v_a <= 16'h001e) || (meas.v_b <= 16'h001e) || (meas.v_c <= 16'h001e);
		cur_hi = imax >= phase_set.pickup;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_phase_off: assert property (phase_set.mode == CPM_DISABLED |=> !operated[0] && !alarm[0])
		else $error("phase element active while disabled");
	chk_neut_nolatch: assert property (neutral_set.mode == CPM_LATCHED |=> !operated[1] && !alarm[1])
		else $error("neutral element acts on latched code");
	chk_relay_mask: assert property (1'b1 |=> relay_out == (({5{operated[0]}} & $past(phase_set.relays))
		| ({5{operated[1]}} & $past(neutral_set.relays)) | ({5{operated[2]}} & $past(pf1_set.relays))
		| ({5{operated[3]}} & $past(pf2_set.relays)))) else $error("relay outputs differ from masks");
	chk_cur_drop: assert property (!cur_hi |=> !operated[0])
		else $error("phase element held below pickup");
	chk_op_cause: assert property ($rose(operated[0]) |-> $past(cur_hi))
		else $error("phase element operated without current");
	chk_volt_loss: assert property (vlow |=> pf_inhibit && operated[3:2] == 2'b00)
		else $error("pf element alive on low voltage");
	chk_pf_enable: assert property (!vlow && (meas.i_a | meas.i_b | meas.i_c) != 16'h0000 |=> !pf_inhibit)
		else $error("pf inhibited with good inputs");
	chk_ctrl_quiet: assert property (pf1_set.mode == CPM_CONTROL |=> !alarm[2])
		else $error("alarm raised in control mode");
	chk_latch_hold: assert property (phase_set.mode == CPM_LATCHED && alarm[0] && !alarm_reset |=> alarm[0])
		else $error("latched alarm lost");
	cover property ($rose(operated[0]));
	cover property ($fell(operated[2]));
	cover property ($fell(alarm[0]));
endmodule // cpm_props
bind cpm_monitor cpm_props cpm_props_inst (.mclk, .rst_b, .meas, .phase_set, .neutral_set, .pf1_set,
	.pf2_set, .alarm_reset, .relay_out, .alarm, .operated, .pf_inhibit);

// *** test/cpm_meas_model.sv ***
// upstream measurement source: balanced phases, pf given in hundredths
// assumes commands change at the mclk rising edge
`timescale 1ns/10ps
module cpm_meas_model import cpm_pkg::*; (
	input wire logic mclk,
	input wire logic [15:0] i_ph,
	input wire logic [15:0] i_nt,
	input wire logic [15:0] volt,
	input wire logic signed [7:0] pf,
	output cpm_meas_t meas
);
	logic signed [31:0] p;
	// apparent power fixed at 10000 so real power is pf times 100
	assign p = $signed(pf) * 32'sd100;
	// registered like a sampler, one extra cycle before the monitor sees a change
	always_ff @(posedge mclk) begin
		meas <= '{i_ph, i_ph, i_ph, i_nt, volt, volt, volt, p, p, p, 32'h00002710, 32'h00002710, 32'h00002710};
	end
endmodule // cpm_meas_model

// *** test/cpm_monitor_tb_top.sv ***
// self-checking bench for cpm_monitor
// assumes TICK_CYCLES of 10, so one second is 10 mclk cycles
`timescale 1ns/10ps
module cpm_monitor_tb_top import cpm_pkg::*;;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] i_ph = 16'h0000;
	logic [15:0] i_nt = 16'h0000;
	logic [15:0] volt = 16'h0064;
	logic signed [7:0] pf = 8'sh64;
	logic alarm_reset = 1'b0;
	cpm_meas_t meas;
	cpm_cur_set_t phase_set = '{CPM_ALARM, 5'h05, 16'h0064, 16'h0002};
	cpm_cur_set_t neutral_set = '{CPM_LATCHED, 5'h10, 16'h0064, 16'h0000};
	cpm_pf_set_t pf1_set = '{CPM_CONTROL, 5'h02, 8'sh50, 8'sh5f, 16'h0001};
	cpm_pf_set_t pf2_set = '{CPM_ALARM, 5'h08, 8'sh32, 8'sh3c, 16'h0000};
	logic [4:0] relay_out;
	logic [3:0] alarm;
	logic [3:0] operated;
	logic pf_inhibit;
	int n_errors = 0;
	int n_compared = 0;
	always #4 mclk = ~mclk;
	cpm_meas_model cpm_meas_model_inst (.mclk(mclk), .i_ph(i_ph), .i_nt(i_nt), .volt(volt), .pf(pf), .meas(meas));
	cpm_monitor #(.TICK_CYCLES(10), .DLY_W(16)) cpm_monitor_inst (.mclk(mclk), .rst_b(rst_b), .meas(meas),
		.phase_set(phase_set), .neutral_set(neutral_set), .pf1_set(pf1_set), .pf2_set(pf2_set),
		.alarm_reset(alarm_reset), .relay_out(relay_out), .alarm(alarm), .operated(operated), .pf_inhibit(pf_inhibit));
	task automatic finish_test();
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// bounded wait on one operated bit, then compare it
	task automatic wait_op(input int b, input logic v);
		int k;
		#1;
		for (k = 0; k < 40 && operated[b] !== v; k++) begin
			cyc(1);
		end
		chk({7'h00, operated[b]}, {7'h00, v});
	endtask
	initial begin
		#20000;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		pf1_set.mode <= CPM_DISABLED;
		pf2_set.mode <= CPM_DISABLED;
		@(posedge mclk);
		i_ph <= 16'h0064;
		cyc(22);
		chk({4'h0, operated}, 8'h00);
		wait_op(0, 1'b1);
		chk({3'h0, relay_out}, 8'h05);
		chk({4'h0, alarm}, 8'h01);
		@(posedge mclk);
		i_ph <= 16'h0063;
		cyc(3);
		chk({4'h0, operated}, 8'h00);
		@(posedge mclk);
		phase_set <= '{CPM_LATCHED, 5'h01, 16'h0064, 16'h0000};
		i_ph <= 16'h00c8;
		wait_op(0, 1'b1);
		@(posedge mclk);
		i_ph <= 16'h0000;
		cyc(4);
		chk({4'h0, alarm}, 8'h01);
		@(posedge mclk);
		alarm_reset <= 1'b1;
		@(posedge mclk);
		alarm_reset <= 1'b0;
		i_nt <= 16'h01f4;
		cyc(2);
		chk({4'h0, alarm}, 8'h00);
		cyc(25);
		chk({4'h0, operated}, 8'h00);
		@(posedge mclk);
		phase_set.mode <= CPM_DISABLED;
		neutral_set.mode <= CPM_CONTROL;
		wait_op(1, 1'b1);
		chk({3'h0, relay_out}, 8'h10);
		chk({4'h0, alarm}, 8'h00);
		@(posedge mclk);
		i_nt <= 16'h0000;
		i_ph <= 16'h0064;
		pf1_set.mode <= CPM_CONTROL;
		pf2_set.mode <= CPM_ALARM;
		pf <= 8'sh46;
		wait_op(2, 1'b1);
		chk({3'h0, relay_out}, 8'h02);
		chk({4'h0, alarm}, 8'h00);
		@(posedge mclk);
		pf <= 8'sh5a;
		cyc(30);
		chk({4'h0, operated}, 8'h04);
		@(posedge mclk);
		pf <= 8'sh64;
		wait_op(2, 1'b0);
		@(posedge mclk);
		pf <= 8'sh28;
		wait_op(3, 1'b1);
		wait_op(2, 1'b1);
		chk({4'h0, alarm}, 8'h08);
		@(posedge mclk);
		volt <= 16'h001e;
		cyc(3);
		chk({3'h0, operated, pf_inhibit}, 8'h01);
		@(posedge mclk);
		volt <= 16'h0064;
		i_ph <= 16'h0000;
		cyc(4);
		chk({7'h00, pf_inhibit}, 8'h01);
		// pf1 timer running with a 3 s delay, then voltage lost before it expires
		@(posedge mclk);
		i_ph <= 16'h0064;
		pf1_set.delay_s <= 16'h0003;
		cyc(15);
		chk({7'h00, operated[2]}, 8'h00);
		@(posedge mclk);
		volt <= 16'h001e;
		cyc(3);
		chk({6'h00, operated[3:2]}, 8'h00);
		@(posedge mclk);
		volt <= 16'h0064;
		cyc(25);
		chk({7'h00, operated[2]}, 8'h00);
		wait_op(2, 1'b1);
		finish_test();
	end
endmodule // cpm_monitor_tb_top
